// [rtl/crf_pkg.sv]
// package: register map, flag positions, reset values and timing counts
package crf_pkg;

  // wishbone word offsets (byte addresses)
  localparam logic [5:0] OFF_ACC    = 6'h00;
  localparam logic [5:0] OFF_INDEX  = 6'h04;
  localparam logic [5:0] OFF_SP     = 6'h08;
  localparam logic [5:0] OFF_PC     = 6'h0c;
  localparam logic [5:0] OFF_FLAGS  = 6'h10;
  localparam logic [5:0] OFF_CMD    = 6'h14;
  localparam logic [5:0] OFF_STATUS = 6'h18;
  localparam logic [5:0] OFF_IREQ   = 6'h1c;
  localparam logic [5:0] OFF_ALU    = 6'h20;
  localparam logic [5:0] OFF_ISR    = 6'h24;

  // condition flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam int FLG_H = 4;
  localparam int FLG_V = 7;

  localparam logic [7:0]  FLAGS_ONES   = 8'h60;
  localparam logic [7:0]  FLAGS_RST    = 8'h68;
  localparam logic [15:0] SP_RST       = 16'h00ff;
  localparam logic [7:0]  SP_LOW_REINIT = 8'hff;

  // vectors
  localparam logic [15:0] VEC_RESET    = 16'hfffe;
  localparam logic [15:0] VEC_BRK      = 16'hfffc;
  localparam logic [15:0] VEC_BRK_MON  = 16'hfefc;
  localparam logic [15:0] VEC_IRQ_BASE = 16'hfff0;
  localparam logic [7:0]  TRAP_OPCODE  = 8'h83;

  // command register operation codes
  localparam logic [3:0] CMD_NONE     = 4'h0;
  localparam logic [3:0] CMD_SP_REINIT = 4'h1;
  localparam logic [3:0] CMD_MASK_CLR = 4'h2;
  localparam logic [3:0] CMD_MASK_SET = 4'h3;
  localparam logic [3:0] CMD_PUSH_H   = 4'h4;
  localparam logic [3:0] CMD_PULL_H   = 4'h5;
  localparam logic [3:0] CMD_RTI      = 4'h6;
  localparam logic [3:0] CMD_WAIT     = 4'h7;
  localparam logic [3:0] CMD_STOP     = 4'h8;
  localparam logic [3:0] CMD_FETCH    = 4'h9;
  localparam logic [3:0] CMD_JUMP     = 4'ha;
  localparam logic [3:0] CMD_INSN_END = 4'hb;

  // alu operation codes
  localparam logic [2:0] ALU_ADD = 3'h0;
  localparam logic [2:0] ALU_ADC = 3'h1;
  localparam logic [2:0] ALU_SUB = 3'h2;
  localparam logic [2:0] ALU_AND = 3'h3;
  localparam logic [2:0] ALU_LSL = 3'h4;
  localparam logic [2:0] ALU_LSR = 3'h5;
  localparam logic [2:0] ALU_LDA = 3'h6;
  localparam logic [2:0] ALU_DAA = 3'h7;

  // oscillator stabilisation after stop exit
  localparam int STAB_NS     = 409600;
  localparam int CLK_NS      = 100;
  localparam int STAB_CYCLES = STAB_NS / CLK_NS;

  localparam int NUM_IRQ   = 4;
  localparam int STACK_LEN = 5;

endpackage : crf_pkg

// [rtl/crf_alu.sv]
// alu: 8-bit result and condition flag results
`timescale 1ns/1ps
module crf_alu (
  input  wire logic [2:0] op_i,
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] m_i,
  input  wire logic [7:0] flags_i,
  output logic      [7:0] res_o,
  output logic      [7:0] flags_o
);
  logic [8:0] sum;
  logic [4:0] lo;
  logic [7:0] adj;
  always_comb
  begin
    sum     = 9'h000;
    lo      = 5'h00;
    adj     = 8'h00;
    flags_o = flags_i;
    res_o   = a_i;
    unique case (op_i)
      crf_pkg::ALU_ADD, crf_pkg::ALU_ADC:
      begin
        sum = {1'b0, a_i} + {1'b0, m_i} + {8'h00, op_i == crf_pkg::ALU_ADC
              && flags_i[crf_pkg::FLG_C]};
        lo  = {1'b0, a_i[3:0]} + {1'b0, m_i[3:0]} + {4'h0, op_i == crf_pkg::ALU_ADC
              && flags_i[crf_pkg::FLG_C]};
        res_o = sum[7:0];
        flags_o[crf_pkg::FLG_H] = lo[4];
        flags_o[crf_pkg::FLG_C] = sum[8];
        flags_o[crf_pkg::FLG_V] = (a_i[7] == m_i[7]) && (sum[7] != a_i[7]);
      end
      crf_pkg::ALU_SUB:
      begin
        sum = {1'b0, a_i} - {1'b0, m_i};
        res_o = sum[7:0];
        flags_o[crf_pkg::FLG_C] = sum[8];
        flags_o[crf_pkg::FLG_V] = (a_i[7] != m_i[7]) && (sum[7] != a_i[7]);
      end
      crf_pkg::ALU_AND:
      begin
        res_o = a_i & m_i;
        flags_o[crf_pkg::FLG_V] = 1'b0;
      end
      crf_pkg::ALU_LSL:
      begin
        res_o = {a_i[6:0], 1'b0};
        flags_o[crf_pkg::FLG_C] = a_i[7];
        flags_o[crf_pkg::FLG_V] = a_i[7] ^ a_i[6];
      end
      crf_pkg::ALU_LSR:
      begin
        res_o = {1'b0, a_i[7:1]};
        flags_o[crf_pkg::FLG_C] = a_i[0];
        flags_o[crf_pkg::FLG_V] = a_i[0];
      end
      crf_pkg::ALU_LDA:
      begin
        res_o = m_i;
        flags_o[crf_pkg::FLG_V] = 1'b0;
      end
      crf_pkg::ALU_DAA:
      begin
        adj[3:0] = (flags_i[crf_pkg::FLG_H] || a_i[3:0] > 4'h9) ? 4'h6 : 4'h0;
        adj[7:4] = (flags_i[crf_pkg::FLG_C] || a_i > 8'h99) ? 4'h6 : 4'h0;
        sum = {1'b0, a_i} + {1'b0, adj};
        res_o = sum[7:0];
        flags_o[crf_pkg::FLG_C] = flags_i[crf_pkg::FLG_C] || (adj[7:4] != 4'h0);
      end
    endcase
    flags_o[crf_pkg::FLG_N] = res_o[7];
    flags_o[crf_pkg::FLG_Z] = (res_o == 8'h00);
    flags_o = flags_o | crf_pkg::FLAGS_ONES;
  end
endmodule : crf_alu

// [rtl/crf_core_regs.sv]
// register set and condition flag control behind a classic wishbone slave
//
// Overview of operation
// - an 8-bit accumulator holds operands and takes alu results
// - a 16-bit index pair is made of high and low bytes
// - reset presets the stack pointer to 0x00ff
// - stack pointer reinit sets its low byte to 0xff, high byte kept
// - stack pointer falls per pushed byte and rises per pulled byte
// - program counter advances per fetch; jumps and interrupts load it
// - leaving reset loads the program counter from the vector at 0xfffe
// - flag bits 6 and 5 read one and ignore writes
// - overflow flag follows two's complement overflow of the result
// - half carry flag records carry from bit 3 to bit 4 on add
// - mask blocks interrupts; set after stacking, before vector fetch
// - interrupt entry never stacks the index high byte
// - with mask clear the highest priority pending request is served first
// - interrupt return restores flags including the mask, acc and pc high byte
// - reset sets the mask; mask clear, wait and stop ops clear it, return reloads it
// - negative flag copies result bit 7
// - zero flag is set when the result is 0x00
// - carry flag records carry or borrow, shifts also update it
// - wait clears mask and halts clock; interrupt exit sets mask after stacking
// - stop clears mask, halts clock, restarts after stabilisation delay
// - break loads trap opcode and vector 0xfffc, or 0xfefc in monitor mode
// - break starts after the instruction or at once on last-cycle match
`timescale 1ns/1ps
module crf_core_regs (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // core side
  input  wire logic [3:0]  irq_req_i,
  input  wire logic        brk_req_i,
  input  wire logic        brk_last_cycle_i,
  input  wire logic        monitor_mode_i,
  output logic             cpu_clk_en_o,
  output logic      [7:0]  insn_reg_o,
  output logic      [15:0] mem_addr_o
);

  typedef enum logic [2:0] {
    ST_RESET_VEC,
    ST_RUN,
    ST_STACK,
    ST_WAIT,
    ST_STOP,
    ST_STAB
  } crf_state_e;

  typedef struct packed {
    crf_state_e  st;
    logic [7:0]  acc;
    logic [15:0] index_pair;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0]  flags;
    logic [7:0]  insn;
    logic [15:0] addr;
    logic [2:0]  stk_cnt;
    logic [15:0] vec;
    logic        brk_pend;
    logic        in_break;
    logic [18:0] stab_cnt;
    logic [31:0] dat;
    logic        ack;
    logic        clk_en;
  } crf_state_s;

  crf_state_s s_r;
  crf_state_s s_nxt;

  logic [7:0] alu_res;
  logic [7:0] alu_flags;

  // =====================================================
  // alu
  crf_alu u_alu (
    .op_i    (dat_i[10:8]),
    .a_i     (s_r.acc),
    .m_i     (dat_i[7:0]),
    .flags_i (s_r.flags),
    .res_o   (alu_res),
    .flags_o (alu_flags)
  );

  // byte lane merge
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction : lane_merge

  // highest priority request, lowest index wins
  function automatic logic [2:0] irq_pick(input logic [3:0] req);
    logic [2:0] r;
    r = 3'h4;
    for (int i = crf_pkg::NUM_IRQ - 1; i >= 0; i--)
    begin
      if (req[i])
        r = 3'(i);
    end
    return r;
  endfunction : irq_pick

  logic [31:0] wr;
  logic        wr_go;
  logic        rd_go;
  logic [2:0]  irq_sel;

  // =====================================================
  // next state
  always_comb
  begin
    s_nxt   = s_r;
    wr      = 32'h0000_0000;
    wr_go   = cyc_i && stb_i && we_i && !s_r.ack;
    rd_go   = cyc_i && stb_i && !we_i && !s_r.ack;
    irq_sel = irq_pick(irq_req_i);
    s_nxt.ack = wr_go || rd_go;
    if (brk_req_i && !s_r.in_break)
      s_nxt.brk_pend = 1'b1;

    unique case (s_r.st)
      ST_RESET_VEC:
      begin
        s_nxt.pc     = crf_pkg::VEC_RESET;
        s_nxt.addr   = crf_pkg::VEC_RESET;
        s_nxt.clk_en = 1'b1;
        s_nxt.st     = ST_RUN;
      end
      ST_RUN:
      begin
        if (brk_req_i && brk_last_cycle_i && !s_r.in_break)
        begin
          s_nxt.insn     = crf_pkg::TRAP_OPCODE;
          s_nxt.vec      = monitor_mode_i ? crf_pkg::VEC_BRK_MON : crf_pkg::VEC_BRK;
          s_nxt.in_break = 1'b1;
          s_nxt.brk_pend = 1'b0;
          s_nxt.stk_cnt  = 3'(crf_pkg::STACK_LEN);
          s_nxt.st       = ST_STACK;
        end
      end
      ST_STACK:
      begin
        // pc lo, pc hi, index lo, acc, flags; index high byte left out
        s_nxt.sp      = s_r.sp - 16'h0001;
        s_nxt.addr    = s_r.sp;
        s_nxt.stk_cnt = s_r.stk_cnt - 3'h1;
        if (s_r.stk_cnt == 3'h1)
        begin
          s_nxt.flags[crf_pkg::FLG_I] = 1'b1;
          s_nxt.pc   = s_r.vec;
          s_nxt.addr = s_r.vec;
          s_nxt.st   = ST_RUN;
        end
      end
      ST_WAIT:
      begin
        if (irq_sel != 3'h4)
        begin
          s_nxt.clk_en  = 1'b1;
          s_nxt.insn    = crf_pkg::TRAP_OPCODE;
          s_nxt.vec     = crf_pkg::VEC_IRQ_BASE - {12'h000, irq_sel, 1'b0};
          s_nxt.stk_cnt = 3'(crf_pkg::STACK_LEN);
          s_nxt.st      = ST_STACK;
        end
      end
      ST_STOP:
      begin
        if (irq_req_i[0])
        begin
          s_nxt.stab_cnt = 19'(crf_pkg::STAB_CYCLES);
          s_nxt.st       = ST_STAB;
        end
      end
      ST_STAB:
      begin
        s_nxt.stab_cnt = s_r.stab_cnt - 19'h00001;
        if (s_r.stab_cnt == 19'h00001)
        begin
          s_nxt.clk_en  = 1'b1;
          s_nxt.vec     = crf_pkg::VEC_IRQ_BASE;
          s_nxt.stk_cnt = 3'(crf_pkg::STACK_LEN);
          s_nxt.st      = ST_STACK;
        end
      end
      default:
        s_nxt.st = ST_RUN;
    endcase

    if (s_r.st == ST_RUN && !(brk_req_i && brk_last_cycle_i && !s_r.in_break))
    begin
      // maskable request taken only while mask clear
      if (!s_r.flags[crf_pkg::FLG_I] && irq_sel != 3'h4 && !wr_go)
      begin
        s_nxt.vec     = crf_pkg::VEC_IRQ_BASE - {12'h000, irq_sel, 1'b0};
        s_nxt.stk_cnt = 3'(crf_pkg::STACK_LEN);
        s_nxt.st      = ST_STACK;
      end
      if (wr_go)
      begin
        unique case (adr_i)
          crf_pkg::OFF_ACC:
            s_nxt.acc = 8'(lane_merge({24'h0, s_r.acc}, dat_i, sel_i));
          crf_pkg::OFF_INDEX:
            s_nxt.index_pair = 16'(lane_merge({16'h0, s_r.index_pair}, dat_i, sel_i));
          crf_pkg::OFF_SP:
            s_nxt.sp = 16'(lane_merge({16'h0, s_r.sp}, dat_i, sel_i));
          crf_pkg::OFF_PC:
            s_nxt.pc = 16'(lane_merge({16'h0, s_r.pc}, dat_i, sel_i));
          crf_pkg::OFF_FLAGS:
          begin
            wr = lane_merge({24'h0, s_r.flags}, dat_i, sel_i);
            s_nxt.flags = wr[7:0] | crf_pkg::FLAGS_ONES;
            s_nxt.flags[crf_pkg::FLG_I] = s_r.flags[crf_pkg::FLG_I];
          end
          crf_pkg::OFF_ALU:
          begin
            if (sel_i[0])
            begin
              s_nxt.acc    = alu_res;
              s_nxt.flags  = alu_flags;
            end
          end
          crf_pkg::OFF_CMD:
          begin
            if (sel_i[0])
            begin
              unique case (dat_i[3:0])
                crf_pkg::CMD_SP_REINIT:
                  s_nxt.sp[7:0] = crf_pkg::SP_LOW_REINIT;
                crf_pkg::CMD_MASK_CLR:
                  s_nxt.flags[crf_pkg::FLG_I] = 1'b0;
                crf_pkg::CMD_MASK_SET:
                  s_nxt.flags[crf_pkg::FLG_I] = 1'b1;
                crf_pkg::CMD_PUSH_H:
                begin
                  s_nxt.addr = s_r.sp;
                  s_nxt.sp   = s_r.sp - 16'h0001;
                end
                crf_pkg::CMD_PULL_H:
                begin
                  s_nxt.sp         = s_r.sp + 16'h0001;
                  s_nxt.index_pair[15:8] = dat_i[15:8];
                end
                crf_pkg::CMD_RTI:
                begin
                  s_nxt.sp = s_r.sp + 16'(crf_pkg::STACK_LEN);
                  s_nxt.flags = dat_i[23:16] | crf_pkg::FLAGS_ONES;
                  s_nxt.acc   = dat_i[15:8];
                  s_nxt.pc    = {dat_i[31:24], s_r.pc[7:0]};
                  if (!brk_req_i)
                    s_nxt.in_break = 1'b0;
                end
                crf_pkg::CMD_WAIT:
                begin
                  s_nxt.flags[crf_pkg::FLG_I] = 1'b0;
                  s_nxt.clk_en = 1'b0;
                  s_nxt.st     = ST_WAIT;
                end
                crf_pkg::CMD_STOP:
                begin
                  s_nxt.flags[crf_pkg::FLG_I] = 1'b0;
                  s_nxt.clk_en = 1'b0;
                  s_nxt.st     = ST_STOP;
                end
                crf_pkg::CMD_FETCH:
                begin
                  s_nxt.addr = s_r.pc;
                  s_nxt.pc   = s_r.pc + 16'h0001;
                end
                crf_pkg::CMD_JUMP:
                begin
                  s_nxt.pc   = dat_i[31:16];
                  s_nxt.addr = dat_i[31:16];
                end
                crf_pkg::CMD_INSN_END:
                begin
                  if (s_r.brk_pend && !s_r.in_break)
                  begin
                    s_nxt.insn     = crf_pkg::TRAP_OPCODE;
                    s_nxt.vec      = monitor_mode_i ? crf_pkg::VEC_BRK_MON
                                                    : crf_pkg::VEC_BRK;
                    s_nxt.in_break = 1'b1;
                    s_nxt.brk_pend = 1'b0;
                    s_nxt.stk_cnt  = 3'(crf_pkg::STACK_LEN);
                    s_nxt.st       = ST_STACK;
                  end
                end
                default:
                  s_nxt.insn = s_r.insn;
              endcase
            end
          end
          default:
            s_nxt.ack = 1'b1;
        endcase
      end
    end

    // read mux; unmapped words read zero
    if (rd_go)
    begin
      unique case (adr_i)
        crf_pkg::OFF_ACC:    s_nxt.dat = {24'h0, s_r.acc};
        crf_pkg::OFF_INDEX:  s_nxt.dat = {16'h0, s_r.index_pair};
        crf_pkg::OFF_SP:     s_nxt.dat = {16'h0, s_r.sp};
        crf_pkg::OFF_PC:     s_nxt.dat = {16'h0, s_r.pc};
        crf_pkg::OFF_FLAGS:  s_nxt.dat = {24'h0, s_r.flags | crf_pkg::FLAGS_ONES};
        crf_pkg::OFF_STATUS: s_nxt.dat = {16'h0, s_r.insn, 2'b00, s_r.brk_pend,
                                          s_r.in_break, s_r.clk_en, s_r.st};
        crf_pkg::OFF_IREQ:   s_nxt.dat = {28'h0, irq_req_i};
        crf_pkg::OFF_ISR:    s_nxt.dat = {16'h0, s_r.addr};
        default:             s_nxt.dat = 32'h0000_0000;
      endcase
    end
  end

  // =====================================================
  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r            <= '0;
      s_r.st         <= ST_RESET_VEC;
      s_r.sp         <= crf_pkg::SP_RST;
      s_r.flags      <= crf_pkg::FLAGS_RST;
      s_r.clk_en     <= 1'b0;
    end
    else
      s_r <= s_nxt;
  end

  assign dat_o        = s_r.dat;
  assign ack_o        = s_r.ack;
  assign cpu_clk_en_o = s_r.clk_en;
  assign insn_reg_o   = s_r.insn;
  assign mem_addr_o   = s_r.addr;

endmodule : crf_core_regs

// [sim/crf_core_regs_asserts.sv]
// checker: bus handshake, read data, flag register and low-power clock enable
`timescale 1ns/1ps
module crf_core_regs_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [5:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        cpu_clk_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // helper logic
  logic        take;
  logic        rd_take;
  logic        lp_take;
  logic        stop_r;
  logic [15:0] low_r;
  assign take    = cyc_i & stb_i & ~ack_o;
  assign rd_take = take & ~we_i;
  assign lp_take = take & we_i & sel_i[0] & (adr_i == crf_pkg::OFF_CMD) & cpu_clk_en_o
                   & (dat_i[3:0] == crf_pkg::CMD_WAIT || dat_i[3:0] == crf_pkg::CMD_STOP);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stop_r <= 1'h0;
      low_r  <= 16'h0;
    end
    else
    begin
      low_r <= cpu_clk_en_o ? 16'h0 : low_r + 16'h1;
      if (lp_take && dat_i[3:0] == crf_pkg::CMD_STOP)
        stop_r <= 1'h1;
      else if (cpu_clk_en_o && low_r != 16'h0)
        stop_r <= 1'h0;
    end
  end
  // ==========================================
  // assertions
  a_ack_next: assert property (take |=> ack_o)
    else $error("request not answered next cycle");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i & stb_i))
    else $error("ack without request");
  a_rst_exit: assert property ($fell(rst_i) |=> cpu_clk_en_o)
    else $error("clock enable not set after reset");
  a_dat_hold: assert property (!(ack_o && !we_i) |-> $stable(dat_o))
    else $error("read data changed outside a read");
  a_flags_ones: assert property (rd_take && adr_i == crf_pkg::OFF_FLAGS |=> dat_o[6:5] == 2'h3)
    else $error("flag bits 6 and 5 not one");
  a_unmapped_zero: assert property (rd_take && adr_i > crf_pkg::OFF_ISR |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_lp_enter: assert property (lp_take |-> ##[1:3] !cpu_clk_en_o)
    else $error("clock not stopped by wait or stop");
  a_stop_stab: assert property ($rose(cpu_clk_en_o) && stop_r |-> low_r >= crf_pkg::STAB_CYCLES)
    else $error("clock restarted before stabilisation");
endmodule : crf_core_regs_chk

bind crf_core_regs crf_core_regs_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .cpu_clk_en_o(cpu_clk_en_o));

// [sim/crf_src_model.sv]
// model of the interrupt and break sources facing the core
`timescale 1ns/1ps
module crf_src_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] irq_set_i,
  input  wire logic [2:0] brk_set_i,
  output logic      [3:0] irq_req_o,
  output logic      [2:0] brk_o
);
  // requests are levels, held until the bench withdraws them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_req_o <= 4'h0;
      brk_o     <= 3'h0;
    end
    else
    begin
      irq_req_o <= irq_set_i;
      brk_o     <= brk_set_i;
    end
  end
endmodule : crf_src_model

// [sim/crf_core_regs_tb_top.sv]
// self-checking bench for the register set and flag control
`timescale 1ns/1ps
module crf_core_regs_tb_top;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        ack;
  logic        clk_en;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [3:0]  irq_set;
  logic [3:0]  irq;
  logic [2:0]  brk_set;
  logic [2:0]  brk;
  logic [7:0]  insn;
  logic [15:0] maddr;
  logic [31:0] dat;
  logic [31:0] rdat;
  logic [31:0] q;
  int          n_fail;
  int          n_checks;
  int          tick;
  int          n;
  // ==========================================
  // instances
  crf_core_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .irq_req_i(irq),
    .brk_req_i(brk[0]), .brk_last_cycle_i(brk[1]), .monitor_mode_i(brk[2]),
    .cpu_clk_en_o(clk_en), .insn_reg_o(insn), .mem_addr_o(maddr));
  crf_src_model u_src (.clk_i(clk_i), .rst_i(rst_i), .irq_set_i(irq_set),
    .brk_set_i(brk_set), .irq_req_o(irq), .brk_o(brk));
  initial
  begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    tick <= tick + 1;
    if (tick == 30000)
    begin
      n_fail++;
      close_out();
    end
  end
  // ==========================================
  // shared tasks
  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic ck(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : ck
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we  <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'h1 && k < 20);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (k >= 20)
      ck({31'h0, ack}, 32'h1, "no ack");
  endtask : wb
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    wb(1'h1, a, d);
  endtask : wr
  task automatic rc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string s);
    wb(1'h0, a, 32'h0);
    ck(q & m, e, s);
  endtask : rc
  task automatic alu(input logic [2:0] op, input logic [7:0] m, input logic [7:0] ea,
                     input logic [7:0] ef);
    wr(crf_pkg::OFF_ALU, {21'h0, op, m});
    rc(crf_pkg::OFF_ACC, 32'hff, {24'h0, ea}, "acc");
    rc(crf_pkg::OFF_FLAGS, 32'hff, {24'h0, ef}, "flags");
  endtask : alu
  task automatic pc_poll(input logic [15:0] e, input string s);
    int k;
    k = 0;
    do
    begin
      wb(1'h0, crf_pkg::OFF_PC, 32'h0);
      k++;
    end
    while (q[15:0] !== e && k < 40);
    ck({16'h0, q[15:0]}, {16'h0, e}, s);
  endtask : pc_poll
  task automatic clk_wait(input int lim);
    n = 0;
    while (clk_en !== 1'h1 && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask : clk_wait
  // ==========================================
  // scenarios
  task automatic t_basic;
    rc(crf_pkg::OFF_SP, 32'hffff, 32'h00ff, "sp reset");
    rc(crf_pkg::OFF_FLAGS, 32'hff, 32'h68, "flags reset");
    rc(crf_pkg::OFF_PC, 32'hffff, 32'hfffe, "pc reset");
    rc(6'h3c, 32'hffffffff, 32'h0, "unmapped");
    wr(crf_pkg::OFF_FLAGS, 32'h0);
    rc(crf_pkg::OFF_FLAGS, 32'hff, 32'h68, "flag write");
    wr(crf_pkg::OFF_CMD, {28'h0, crf_pkg::CMD_MASK_CLR});
    rc(crf_pkg::OFF_FLAGS, 32'hff, 32'h60, "mask clear");
    wr(crf_pkg::OFF_FLAGS, 32'hff);
    rc(crf_pkg::OFF_FLAGS, 32'hff, 32'hf7, "flag write");
    wr(crf_pkg::OFF_FLAGS, 32'h60);
    wr(crf_pkg::OFF_SP, 32'h1234);
    wr(crf_pkg::OFF_CMD, {28'h0, crf_pkg::CMD_SP_REINIT});
    rc(crf_pkg::OFF_SP, 32'hffff, 32'h12ff, "sp reinit");
    wr(crf_pkg::OFF_INDEX, 32'hbeef);
    rc(crf_pkg::OFF_INDEX, 32'hffff, 32'hbeef, "index");
    wr(crf_pkg::OFF_CMD, {28'h0, crf_pkg::CMD_PUSH_H});
    rc(crf_pkg::OFF_SP, 32'hffff, 32'h12fe, "push");
    ck({16'h0, maddr}, 32'h12ff, "push address");
    wr(crf_pkg::OFF_CMD, {16'h0, 8'ha5, 4'h0, crf_pkg::CMD_PULL_H});
    rc(crf_pkg::OFF_SP, 32'hffff, 32'h12ff, "pull");
    rc(crf_pkg::OFF_INDEX, 32'hffff, 32'ha5ef, "pull high");
    wr(crf_pkg::OFF_PC, 32'h1000);
    wr(crf_pkg::OFF_CMD, {28'h0, crf_pkg::CMD_FETCH});
    wr(crf_pkg::OFF_CMD, {28'h0, crf_pkg::CMD_FETCH});
    rc(crf_pkg::OFF_PC, 32'hffff, 32'h1002, "fetch");
    wr(crf_pkg::OFF_CMD, {16'h2345, 12'h0, crf_pkg::CMD_JUMP});
    rc(crf_pkg::OFF_PC, 32'hffff, 32'h2345, "jump");
    $display("registers done");
  endtask : t_basic
  task automatic t_alu;
    wr(crf_pkg::OFF_ACC, 32'h7f);
    alu(crf_pkg::ALU_ADD, 8'h01, 8'h80, 8'hf4);
    alu(crf_pkg::ALU_ADD, 8'h80, 8'h00, 8'he3);
    alu(crf_pkg::ALU_SUB, 8'h01, 8'hff, 8'h65);
    alu(crf_pkg::ALU_ADC, 8'h00, 8'h00, 8'h73);
    alu(crf_pkg::ALU_LDA, 8'h81, 8'h81, 8'h75);
    alu(crf_pkg::ALU_LSL, 8'h00, 8'h02, 8'hf1);
    alu(crf_pkg::ALU_LSR, 8'h00, 8'h01, 8'h70);
    alu(crf_pkg::ALU_AND, 8'hfe, 8'h00, 8'h72);
    wr(crf_pkg::OFF_ALU, {21'h0, crf_pkg::ALU_DAA, 8'h00});
    rc(crf_pkg::OFF_ACC, 32'hff, 32'h06, "adjust");
    $display("alu done");
  endtask : t_alu
  task automatic t_irq;
    wr(crf_pkg::OFF_SP, 32'h00ff);
    irq_set <= 4'h6;
    pc_poll(16'hffee, "priority");
    rc(crf_pkg::OFF_SP, 32'hffff, 32'h00fa, "stacking");
    rc(crf_pkg::OFF_FLAGS, 32'h08, 32'h08, "mask on entry");
    irq_set <= 4'h1;
    repeat (30) @(posedge clk_i);
    rc(crf_pkg::OFF_PC, 32'hffff, 32'hffee, "masked");
    irq_set <= 4'h0;
    wr(crf_pkg::OFF_CMD, {8'h20, 8'h60, 8'h11, 4'h0, crf_pkg::CMD_RTI});
    rc(crf_pkg::OFF_SP, 32'hffff, 32'h00ff, "return sp");
    rc(crf_pkg::OFF_FLAGS, 32'hff, 32'h60, "return flags");
    rc(crf_pkg::OFF_ACC, 32'hff, 32'h11, "return acc");
    $display("interrupt done");
  endtask : t_irq
  task automatic t_low_power;
    wr(crf_pkg::OFF_CMD, {28'h0, crf_pkg::CMD_WAIT});
    repeat (3) @(posedge clk_i);
    ck({31'h0, clk_en}, 32'h0, "wait clock");
    rc(crf_pkg::OFF_FLAGS, 32'h08, 32'h0, "wait mask");
    irq_set <= 4'h4;
    clk_wait(50);
    ck({31'h0, clk_en}, 32'h1, "wait exit");
    pc_poll(16'hffec, "wait vector");
    irq_set <= 4'h0;
    wr(crf_pkg::OFF_CMD, {8'h00, 8'h60, 8'h00, 4'h0, crf_pkg::CMD_RTI});
    wr(crf_pkg::OFF_CMD, {28'h0, crf_pkg::CMD_STOP});
    repeat (20) @(posedge clk_i);
    irq_set <= 4'h1;
    clk_wait(5000);
    ck({31'h0, n >= crf_pkg::STAB_CYCLES && n <= crf_pkg::STAB_CYCLES + 40}, 32'h1,
       "stop delay");
    irq_set <= 4'h0;
    $display("low power done");
  endtask : t_low_power
  task automatic t_brk;
    wr(crf_pkg::OFF_CMD, {28'h0, crf_pkg::CMD_WAIT});
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    ck({24'h0, insn}, 32'h0, "reset insn");
    rc(crf_pkg::OFF_FLAGS, 32'hff, 32'h68, "reset exit mask");
    wr(crf_pkg::OFF_CMD, {28'h0, crf_pkg::CMD_MASK_SET});
    brk_set <= 3'h5;
    repeat (2) @(posedge clk_i);
    wr(crf_pkg::OFF_CMD, {28'h0, crf_pkg::CMD_INSN_END});
    pc_poll(16'hfefc, "monitor break");
    ck({24'h0, insn}, 32'h83, "trap opcode");
    wr(crf_pkg::OFF_CMD, {8'h00, 8'h68, 8'h00, 4'h0, crf_pkg::CMD_RTI});
    rc(crf_pkg::OFF_STATUS, 32'h10, 32'h10, "break held");
    brk_set <= 3'h0;
    wr(crf_pkg::OFF_CMD, {8'h00, 8'h68, 8'h00, 4'h0, crf_pkg::CMD_RTI});
    rc(crf_pkg::OFF_STATUS, 32'h10, 32'h0, "break left");
    brk_set <= 3'h3;
    pc_poll(16'hfffc, "break at once");
    brk_set <= 3'h0;
    $display("break done");
  endtask : t_brk
  // ==========================================
  // main sequence
  initial
  begin
    rst_i = 1'h1;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 6'h0;
    sel = 4'hf;
    dat = 32'h0;
    irq_set = 4'h0;
    brk_set = 3'h0;
    n_fail = 0;
    n_checks = 0;
    tick = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    t_basic();
    t_alu();
    t_irq();
    t_low_power();
    t_brk();
    close_out();
  end
endmodule : crf_core_regs_tb_top
